/* exec_slice.sv */
// Execution slice: immediate branch, break, barrel shift, compare, stream read
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "exec_slice_map.svh"

module exec_slice
    import exec_slice_pkg::*;
#(
    parameter bit USE_SHIFTER = 1'b1
) (
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    // Issue port
    input  wire logic        issue_valid_in,
    input  wire issue_t      issue_in,
    // Stream link
    input  wire stream_t     stream_in,
    output logic             stream_ack_out,
    // Register writeback
    output logic             wr_en_out,
    output logic [4:0]       wr_dest_out,
    output logic [31:0]      wr_data_out,
    // Fetch redirect
    output logic             redirect_out,
    output logic [31:0]      target_out,
    output logic             slot_allowed_out,
    // Status and handshake
    output logic             done_out,
    output logic             stall_out,
    output logic             irq_block_out,
    output logic [31:0]      machine_status_word_out,
    output logic             break_in_progress_flag_out
);

    localparam int SHAMT_W = `FLD_SHAMT_MSB - `FLD_SHAMT_LSB + 1;

    // Elaboration guard: the shifter and the compare assume a five-bit amount
    // and a 32-bit word; a shift amount field of any other width is refused before it is built
    if (SHAMT_W != 5) begin : g_bad_shamt
        $error("exec_slice: shift amount field must be five bits");
    end

    slice_state_t cur;
    slice_state_t next_cur;

    logic [31:0]        ext_imm;
    logic [31:0]        shifted;
    logic [SHAMT_W-1:0] shamt;
    logic [31:0]        diff;
    logic               a_gt_b;
    logic               ctrl_expect;

    // Immediate operand: prefix pairing or sign extension
    always_comb begin
        if (cur.prefix_held) begin
            ext_imm = {cur.prefix_hi, issue_in.imm};
        end else begin
            ext_imm = {{16{issue_in.imm[`FLD_IMM_MSB]}}, issue_in.imm};
        end
    end

    // Barrel shifter; the immediate form never sees the prefix
    // Shifter is purely combinational: the second cycle only waits for the
    // write port, trading a spare cycle for a short critical path
    always_comb begin
        if (issue_in.op == OP_SHIFT_IMM) begin
            shamt = issue_in.imm[`FLD_SHAMT_MSB:`FLD_SHAMT_LSB];
        end else begin
            shamt = issue_in.src_b_reg[`FLD_SHAMT_MSB:`FLD_SHAMT_LSB];
        end
        if (issue_in.side_left) begin
            shifted = issue_in.src_a_reg << shamt;
        end else if (issue_in.arith) begin
            // Zero amount passes the operand unchanged by construction
            shifted = $unsigned($signed(issue_in.src_a_reg) >>> shamt);
        end else begin
            shifted = issue_in.src_a_reg >> shamt;
        end
    end

    // Compare: b minus a, MSB replaced by a greater than b
    always_comb begin
        diff = issue_in.src_b_reg - issue_in.src_a_reg;
        if (issue_in.is_unsigned) begin
            a_gt_b = issue_in.src_a_reg > issue_in.src_b_reg;
        end else begin
            a_gt_b = $signed(issue_in.src_a_reg) > $signed(issue_in.src_b_reg);
        end
        ctrl_expect = issue_in.ctrl_form;
    end

    // Next-state logic for the whole slice
    always_comb begin
        next_cur = cur;
        next_cur.wr_en      = 1'b0;
        next_cur.redirect   = 1'b0;
        next_cur.slot_allowed = 1'b0;
        next_cur.done       = 1'b0;
        next_cur.stream_ack = 1'b0;
        unique case (cur.state)
            ST_IDLE: begin
                next_cur.stall = 1'b0;
                if (issue_valid_in) begin
                    // A prefix is consumed by the very next instruction
                    next_cur.prefix_held = 1'b0;
                    next_cur.irq_block   = 1'b0;
                    unique case (issue_in.op)
                        OP_PREFIX: begin
                            next_cur.prefix_held = 1'b1;
                            next_cur.prefix_hi   = issue_in.imm;
                            next_cur.irq_block   = 1'b1;
                            next_cur.done        = 1'b1;
                        end
                        OP_BRANCH_IMM: begin
                            // Non-delayed linking forms are not valid encodings
                            next_cur.pend_wr   = issue_in.link && issue_in.delay;
                            next_cur.pend_dest = issue_in.dest;
                            next_cur.pend_data = issue_in.pc;
                            next_cur.pend_redirect = 1'b1;
                            next_cur.pend_target = issue_in.absolute ?
                                ext_imm : issue_in.pc + ext_imm;
                            next_cur.pend_slot = issue_in.delay;
                            next_cur.count = issue_in.delay ?
                                2'(`LAT_BRANCH_DELAY - 1) :
                                2'(`LAT_BRANCH_NODELAY - 1);
                            next_cur.state = ST_BUSY;
                            next_cur.stall = 1'b1;
                        end
                        OP_BREAK_REG, OP_BREAK_IMM: begin
                            next_cur.pend_wr   = 1'b1;
                            next_cur.pend_dest = issue_in.dest;
                            next_cur.pend_data = issue_in.pc;
                            next_cur.pend_redirect = 1'b1;
                            next_cur.pend_target = (issue_in.op == OP_BREAK_REG) ?
                                issue_in.src_b_reg : ext_imm;
                            next_cur.pend_slot = 1'b0;
                            next_cur.msw[`MSW_BIP_BIT] = 1'b1;
                            next_cur.count = 2'(`LAT_BREAK - 1);
                            next_cur.state = ST_BUSY;
                            next_cur.stall = 1'b1;
                        end
                        OP_SHIFT_REG, OP_SHIFT_IMM: begin
                            // Without the shifter option the op is ignored
                            if (USE_SHIFTER) begin
                                next_cur.pend_wr   = 1'b1;
                                next_cur.pend_dest = issue_in.dest;
                                next_cur.pend_data = shifted;
                                next_cur.pend_redirect = 1'b0;
                                next_cur.pend_slot = 1'b0;
                                next_cur.count = 2'(`LAT_SHIFT - 1);
                                next_cur.state = ST_BUSY;
                                next_cur.stall = 1'b1;
                            end else begin
                                next_cur.done = 1'b1;
                            end
                        end
                        OP_COMPARE: begin
                            next_cur.wr_en   = 1'b1;
                            next_cur.wr_dest = issue_in.dest;
                            next_cur.wr_data = {a_gt_b, diff[30:0]};
                            next_cur.done    = 1'b1;
                        end
                        OP_STREAM_READ: begin
                            next_cur.pend_dest = issue_in.dest;
                            next_cur.pend_redirect = 1'b0;
                            next_cur.pend_slot = 1'b0;
                            next_cur.count = 2'(`LAT_STREAM - 1);
                            if (issue_in.nonblock || stream_in.valid) begin
                                next_cur.pend_wr   = 1'b1;
                                next_cur.pend_data = stream_in.data;
                                next_cur.stream_ack = stream_in.valid;
                                if (issue_in.nonblock) begin
                                    next_cur.msw[`MSW_CARRY_BIT] = ~stream_in.valid;
                                end
                                next_cur.msw[`MSW_STREAM_ERR_BIT] =
                                    (stream_in.ctrl != ctrl_expect);
                                next_cur.state = ST_BUSY;
                            end else begin
                                // Remember the expected form while waiting
                                next_cur.pend_slot = ctrl_expect;
                                next_cur.state = ST_STREAM_WAIT;
                            end
                            next_cur.stall = 1'b1;
                        end
                        default: begin
                            next_cur.done = 1'b1;
                        end
                    endcase
                end
            end
            ST_STREAM_WAIT: begin
                // Blocking read holds the issue stage until a word arrives
                // Limitation: no time-out here, a silent link stalls forever
                if (stream_in.valid) begin
                    next_cur.pend_wr   = 1'b1;
                    next_cur.pend_data = stream_in.data;
                    next_cur.stream_ack = 1'b1;
                    next_cur.msw[`MSW_STREAM_ERR_BIT] =
                        (stream_in.ctrl != cur.pend_slot);
                    next_cur.pend_slot = 1'b0;
                    next_cur.count = 2'(`LAT_STREAM - 1);
                    next_cur.state = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (cur.count == 2'h1) begin
                    // Final cycle: commit results and redirect
                    next_cur.wr_en   = cur.pend_wr;
                    next_cur.wr_dest = cur.pend_dest;
                    next_cur.wr_data = cur.pend_data;
                    next_cur.redirect = cur.pend_redirect;
                    next_cur.target   = cur.pend_target;
                    next_cur.slot_allowed = cur.pend_slot;
                    next_cur.done  = 1'b1;
                    next_cur.stall = 1'b0;
                    next_cur.state = ST_IDLE;
                end
                next_cur.count = cur.count - 2'h1;
            end
        endcase
        // Interrupt lock only while a prefix waits for its partner
        next_cur.irq_block = next_cur.prefix_held;
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cur <= '{state: ST_IDLE, msw: `MSW_RESET, target: `FLD_RESET_PC,
                     default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state flops
    assign stream_ack_out   = cur.stream_ack;
    assign wr_en_out        = cur.wr_en;
    assign wr_dest_out      = cur.wr_dest;
    assign wr_data_out      = cur.wr_data;
    assign redirect_out     = cur.redirect;
    assign target_out       = cur.target;
    assign slot_allowed_out = cur.slot_allowed;
    assign done_out         = cur.done;
    assign stall_out        = cur.stall;
    assign irq_block_out    = cur.irq_block;
    assign machine_status_word_out    = cur.msw;
    assign break_in_progress_flag_out = cur.msw[`MSW_BIP_BIT];

endmodule : exec_slice

/* exec_slice_map.svh */
// Offsets, field positions, reset values and cycle counts of the execution slice
`ifndef EXEC_SLICE_MAP_SVH
`define EXEC_SLICE_MAP_SVH

// Machine status word bit positions
`define MSW_CARRY_BIT        0
`define MSW_BIP_BIT          3
`define MSW_STREAM_ERR_BIT   4
`define MSW_RESET            32'h0000_0000

// Instruction field positions (bit 0 is the LSB here)
`define FLD_IMM_LSB          0
`define FLD_IMM_MSB          15
`define FLD_SHAMT_LSB        0
`define FLD_SHAMT_MSB        4
`define FLD_RESET_PC         32'h0000_0000

// Instruction latencies in cycles
`define LAT_BRANCH_DELAY     2
`define LAT_BRANCH_NODELAY   3
`define LAT_BREAK            3
`define LAT_SHIFT            2
`define LAT_COMPARE          1
`define LAT_STREAM           2

`endif

/* exec_slice_pkg.sv */
// Types of the execution slice: operations, request and result carriers, state
package exec_slice_pkg;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_PREFIX,
        OP_BRANCH_IMM,
        OP_BREAK_REG,
        OP_BREAK_IMM,
        OP_SHIFT_REG,
        OP_SHIFT_IMM,
        OP_COMPARE,
        OP_STREAM_READ
    } op_t;

    // One decoded instruction as presented by the issue stage
    typedef struct packed {
        op_t         op;
        logic        link;        // Branch link flag
        logic        absolute;    // Branch absolute flag
        logic        delay;       // Branch delay flag
        logic        side_left;   // Shift side bit
        logic        arith;       // Shift type bit
        logic        is_unsigned; // Compare unsigned flag
        logic        nonblock;    // Stream read non-blocking flag
        logic        ctrl_form;   // Stream read control form
        logic [4:0]  dest;
        logic [15:0] imm;
        logic [31:0] src_a_reg;
        logic [31:0] src_b_reg;
        logic [31:0] pc;
    } issue_t;

    // Word presented by the stream link
    typedef struct packed {
        logic        valid;
        logic        ctrl;
        logic [31:0] data;
    } stream_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY,
        ST_STREAM_WAIT
    } state_t;

    // Whole state of the slice
    typedef struct packed {
        state_t      state;
        logic [1:0]  count;
        logic        prefix_held;
        logic [15:0] prefix_hi;
        logic        wr_en;
        logic [4:0]  wr_dest;
        logic [31:0] wr_data;
        logic        redirect;
        logic [31:0] target;
        logic        slot_allowed;
        logic        done;
        logic        stall;
        logic        irq_block;
        logic        stream_ack;
        logic [31:0] msw;
        logic        pend_wr;
        logic [4:0]  pend_dest;
        logic [31:0] pend_data;
        logic        pend_redirect;
        logic [31:0] pend_target;
        logic        pend_slot;
    } slice_state_t;

endpackage : exec_slice_pkg

/* exec_slice_props.sv */
// Port checker of the execution slice, bound to the design
`timescale 1ns/1ns
module exec_slice_props
    import exec_slice_pkg::*;
#(
    parameter bit USE_SHIFTER = 1'b1
) (
    // Clock, reset and inputs
    input wire logic        clk_sys_in,
    input wire logic        nrst_in,
    input wire logic        issue_valid_in,
    input wire issue_t      issue_in,
    input wire stream_t     stream_in,
    // Outputs watched
    input wire logic        wr_en_out,
    input wire logic [31:0] wr_data_out,
    input wire logic        redirect_out,
    input wire logic [31:0] target_out,
    input wire logic        slot_allowed_out,
    input wire logic        done_out,
    input wire logic        stall_out,
    input wire logic        irq_block_out,
    input wire logic        break_in_progress_flag_out
);
    logic        take;
    logic        pre_live;
    logic        held_pre;
    logic [15:0] pfx;
    issue_t      held;
    default clocking dc @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    assign take = issue_valid_in && !stall_out;
    // Last taken instruction; prefix tracked here, not trusted from the design
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            held     <= '0;
            pre_live <= 1'b0;
            held_pre <= 1'b0;
            pfx      <= '0;
        end else if (take) begin
            held     <= issue_in;
            pre_live <= (issue_in.op == OP_PREFIX);
            held_pre <= pre_live;
            if (issue_in.op == OP_PREFIX) pfx <= issue_in.imm;
        end
    end
    function automatic logic [31:0] sx(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction : sx
    // Difference with the relation forced into the top bit
    function automatic logic [31:0] cmpr(input issue_t i);
        logic [31:0] d;
        d     = i.src_b_reg - i.src_a_reg;
        d[31] = i.is_unsigned ? (i.src_a_reg > i.src_b_reg)
                              : ($signed(i.src_a_reg) > $signed(i.src_b_reg));
        return d;
    endfunction : cmpr
    function automatic logic [31:0] shf(input issue_t i);
        if (i.side_left) return i.src_a_reg << i.src_b_reg[4:0];
        if (i.arith) return $unsigned($signed(i.src_a_reg) >>> i.src_b_reg[4:0]);
        return i.src_a_reg >> i.src_b_reg[4:0];
    endfunction : shf
    sequence s_two;
        !done_out ##1 done_out;
    endsequence
    sequence s_three;
        !done_out [*2] ##1 done_out;
    endsequence
    a_compare_one_cycle: assert property (
        take && issue_in.op == OP_COMPARE
        |=> done_out && wr_en_out && wr_data_out == cmpr(held))
        else $error("compare result or timing wrong");
    a_branch_delay_slot: assert property (
        take && issue_in.op == OP_BRANCH_IMM && issue_in.delay
        |=> s_two ##0 (redirect_out && slot_allowed_out))
        else $error("delayed branch timing wrong");
    a_branch_no_delay: assert property (
        take && issue_in.op == OP_BRANCH_IMM && !issue_in.delay
        |=> s_three ##0 (redirect_out && !slot_allowed_out))
        else $error("undelayed branch timing wrong");
    a_branch_target_calc: assert property (
        redirect_out && held.op == OP_BRANCH_IMM && !held_pre
        |-> target_out == (held.absolute ? sx(held.imm) : held.pc + sx(held.imm)))
        else $error("branch target wrong");
    a_prefix_upper_half: assert property (
        redirect_out && held_pre && held.op == OP_BRANCH_IMM && held.absolute
        |-> target_out == {pfx, held.imm})
        else $error("prefixed target wrong");
    a_link_pc_write: assert property (
        done_out && held.op == OP_BRANCH_IMM && held.link
        |-> wr_en_out == held.delay && (!held.delay || wr_data_out == held.pc))
        else $error("link write wrong");
    a_break_three_cycles: assert property (
        take && issue_in.op inside {OP_BREAK_REG, OP_BREAK_IMM}
        |=> s_three ##0 (redirect_out && wr_en_out && break_in_progress_flag_out))
        else $error("break timing or flag wrong");
    a_break_target_pc: assert property (
        redirect_out && held.op inside {OP_BREAK_REG, OP_BREAK_IMM} && !held_pre
        |-> wr_data_out == held.pc && target_out ==
            (held.op == OP_BREAK_REG ? held.src_b_reg : sx(held.imm)))
        else $error("break target or saved pc wrong");
    a_shift_result: assert property (
        USE_SHIFTER && take && issue_in.op == OP_SHIFT_REG
        |=> s_two ##0 (wr_en_out && wr_data_out == shf(held)))
        else $error("shift result or timing wrong");
    a_stream_blocks: assert property (
        take && issue_in.op == OP_STREAM_READ && !issue_in.nonblock && !stream_in.valid
        |=> stall_out && !done_out)
        else $error("blocking read did not stall");
    a_prefix_no_irq: assert property (
        take && issue_in.op == OP_PREFIX |=> irq_block_out)
        else $error("prefix left interrupts open");
endmodule : exec_slice_props

bind exec_slice exec_slice_props #(
    .USE_SHIFTER(USE_SHIFTER)
) exec_slice_props_i (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .issue_valid_in(issue_valid_in),
    .issue_in(issue_in), .stream_in(stream_in), .wr_en_out(wr_en_out),
    .wr_data_out(wr_data_out), .redirect_out(redirect_out), .target_out(target_out),
    .slot_allowed_out(slot_allowed_out), .done_out(done_out), .stall_out(stall_out),
    .irq_block_out(irq_block_out), .break_in_progress_flag_out(break_in_progress_flag_out)
);

/* exec_slice_tb_top.sv */
// Self-checking bench of the execution slice with a stream source
`timescale 1ns/1ns
module exec_slice_tb_top
    import exec_slice_pkg::*;
;
    typedef struct {
        issue_t      ins;
        logic        pre;
        logic [15:0] pv;
        int          lat;
        logic [2:0]  fl;
        logic [31:0] tgt;
        logic [31:0] wd;
    } row_t;
    logic        clk_sys_in, nrst_in, issue_valid_in, push, push_ctrl;
    logic        stream_ack_out, wr_en_out, redirect_out, slot_allowed_out;
    logic        done_out, stall_out, irq_block_out, break_in_progress_flag;
    logic [4:0]  wr_dest_out;
    logic [31:0] wr_data_out, target_out, msw, push_data;
    issue_t      issue_in;
    stream_t     stream_in;
    int          errors, cmp_count, acks, lat;
    row_t        rows [14];
    exec_slice exec_slice_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .issue_valid_in(issue_valid_in), .issue_in(issue_in), .stream_in(stream_in),
        .stream_ack_out(stream_ack_out), .wr_en_out(wr_en_out), .wr_dest_out(wr_dest_out),
        .wr_data_out(wr_data_out), .redirect_out(redirect_out), .target_out(target_out),
        .slot_allowed_out(slot_allowed_out), .done_out(done_out), .stall_out(stall_out),
        .irq_block_out(irq_block_out), .machine_status_word_out(msw),
        .break_in_progress_flag_out(break_in_progress_flag));
    stream_source stream_source_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .push_in(push), .push_ctrl_in(push_ctrl), .push_data_in(push_data),
        .ack_in(stream_ack_out), .stream_out(stream_in));
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    // Words popped by the slice
    always @(posedge clk_sys_in) if (stream_ack_out === 1'b1) acks++;
    function automatic issue_t mk(op_t op, logic [7:0] f, logic [15:0] imm,
                                  logic [31:0] a, logic [31:0] b);
        mk = '0;
        mk.op = op;
        {mk.link, mk.absolute, mk.delay, mk.side_left, mk.arith, mk.is_unsigned,
         mk.nonblock, mk.ctrl_form} = f;
        mk.dest = 5'h07;
        mk.imm = imm;
        mk.src_a_reg = a;
        mk.src_b_reg = b;
        mk.pc = 32'h0000_1000;
    endfunction : mk
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic put(input issue_t i);
        @(posedge clk_sys_in);
        issue_valid_in <= 1'b1;
        issue_in <= i;
        @(posedge clk_sys_in);
        issue_valid_in <= 1'b0;
    endtask : put
    // Issue, then count cycles to done; lat 1 is the cycle after the taking edge
    task automatic run(input issue_t i);
        put(i);
        for (lat = 1; lat < 60; lat++) begin
            #1;
            if (done_out === 1'b1) break;
            @(posedge clk_sys_in);
        end
    endtask : run
    task automatic load(input logic c, input logic [31:0] d);
        @(posedge clk_sys_in);
        push <= 1'b1;
        push_ctrl <= c;
        push_data <= d;
        @(posedge clk_sys_in);
        push <= 1'b0;
    endtask : load
    task automatic wrap_up;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        #(4000 * 50);
        errors++;
        wrap_up();
    end
    initial begin
        {issue_valid_in, push, push_ctrl, push_data, issue_in} = '0;
        {errors, cmp_count, acks} = '0;
        nrst_in = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        rows[0] = '{mk(OP_COMPARE, 8'h00, 0, 1, 32'hffff_ffff), 0, 0, 1, 1, 0, 32'hffff_fffe};
        rows[1] = '{mk(OP_COMPARE, 8'h04, 0, 1, 32'hffff_ffff), 0, 0, 1, 1, 0, 32'h7fff_fffe};
        rows[2] = '{mk(OP_COMPARE, 8'h00, 0, 3, 5), 0, 0, 1, 1, 0, 32'h0000_0002};
        rows[3] = '{mk(OP_SHIFT_REG, 8'h10, 0, 32'h8000_00f0, 32'hffff_ffe4), 0, 0, 2, 1, 0,
                    32'h0000_0f00};
        rows[4] = rows[3];
        rows[4].ins.side_left = 1'b0;
        rows[4].wd = 32'h0800_000f;
        rows[5] = rows[4];
        rows[5].ins.arith = 1'b1;
        rows[5].wd = 32'hf800_000f;
        rows[6] = rows[5];
        rows[6].ins.src_b_reg = 32'h0000_0020;
        rows[6].wd = 32'h8000_00f0;
        rows[7] = '{mk(OP_SHIFT_IMM, 8'h10, 8, 32'h8000_00f0, 0), 1, 1, 2, 1, 0, 32'h0000_f000};
        rows[8] = '{mk(OP_BRANCH_IMM, 8'ha0, 16'hfff0, 0, 0), 0, 0, 2, 7, 32'h0ff0, 32'h1000};
        rows[9] = '{mk(OP_BRANCH_IMM, 8'h40, 16'h8004, 0, 0), 0, 0, 3, 4, 32'hffff_8004, 0};
        rows[10] = '{mk(OP_BRANCH_IMM, 8'h80, 16'h0010, 0, 0), 0, 0, 3, 4, 32'h1010, 0};
        rows[11] = '{mk(OP_BRANCH_IMM, 8'h60, 16'h8000, 0, 0), 1, 16'h1234, 2, 6,
                     32'h1234_8000, 0};
        rows[12] = '{mk(OP_BREAK_REG, 8'h00, 0, 0, 32'h2000), 0, 0, 3, 5, 32'h2000, 32'h1000};
        rows[13] = '{mk(OP_BREAK_IMM, 8'h00, 16'hff00, 0, 0), 0, 0, 3, 5, 32'hffff_ff00,
                     32'h1000};
        chk(break_in_progress_flag, 1'b0);
        foreach (rows[k]) begin
            if (rows[k].pre) begin
                put(mk(OP_PREFIX, 8'h00, rows[k].pv, 0, 0));
                #1 chk(irq_block_out, 1'b1);
            end
            run(rows[k].ins);
            chk(lat, rows[k].lat);
            chk({redirect_out, slot_allowed_out, wr_en_out}, rows[k].fl);
            if (rows[k].fl[2]) chk(target_out, rows[k].tgt);
            if (rows[k].fl[0]) chk(wr_data_out, rows[k].wd);
        end
        chk({break_in_progress_flag, msw[3], wr_dest_out}, 7'h67);
        run(mk(OP_STREAM_READ, 8'h02, 0, 0, 0));
        chk({lat[3:0], msw[0]}, 5'h05);
        load(1'b0, 32'hcafe_0001);
        run(mk(OP_STREAM_READ, 8'h02, 0, 0, 0));
        chk({lat[3:0], msw[4], msw[0]}, 6'h08);
        chk(wr_data_out, 32'hcafe_0001);
        // Word arrives late and with the wrong control bit
        fork
            run(mk(OP_STREAM_READ, 8'h00, 0, 0, 0));
            begin
                repeat (6) @(posedge clk_sys_in);
                load(1'b1, 32'h5a5a_0002);
            end
        join
        chk({lat[3:0], msw[4]}, 5'h13);
        chk(wr_data_out, 32'h5a5a_0002);
        load(1'b1, 32'h00c0_ffee);
        run(mk(OP_STREAM_READ, 8'h01, 0, 0, 0));
        chk({lat[3:0], msw[4]}, 5'h04);
        chk(wr_data_out, 32'h00c0_ffee);
        chk(acks, 3);
        // Mid-run reset is the only way the sticky break flag clears
        nrst_in <= 1'b0;
        @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        #1 chk(msw, 32'h0000_0000);
        wrap_up();
    end
endmodule : exec_slice_tb_top

/* stream_source.sv */
// Stream link source: small FIFO feeding the slice
`timescale 1ns/1ns
module stream_source
    import exec_slice_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    // Loading side and pop
    input  wire logic        push_in,
    input  wire logic        push_ctrl_in,
    input  wire logic [31:0] push_data_in,
    input  wire logic        ack_in,
    // Head of the FIFO
    output stream_t          stream_out
);
    logic [32:0] mem [4];
    logic [1:0]  rd;
    logic [1:0]  wr;
    logic [2:0]  cnt;
    logic [32:0] junk;
    logic        pop;
    assign pop = ack_in && (cnt != 3'h0);
    // Store and pop; no overflow guard, the bench loads only three words in all
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd   <= '0;
            wr   <= '0;
            cnt  <= '0;
            junk <= '0;
        end else begin
            junk <= ~junk;
            if (push_in) begin
                mem[wr] <= {push_ctrl_in, push_data_in};
                wr      <= wr + 2'h1;
            end
            if (pop) rd <= rd + 2'h1;
            cnt <= cnt + {2'h0, push_in} - {2'h0, pop};
        end
    end
    // Empty head shows churning bits so stale data cannot pass as valid
    assign stream_out.valid = (cnt != 3'h0);
    assign {stream_out.ctrl, stream_out.data} = (cnt != 3'h0) ? mem[rd] : junk;
endmodule : stream_source
